// ### logic/cscd_regs.svh
// constants for the camera settings command decoder
`ifndef CSCD_REGS_SVH
`define CSCD_REGS_SVH
// ****************************************
// command codes
// ****************************************
`define CSCD_CMD_LOFS 8'h81
`define CSCD_CMD_ROFS 8'h83
`define CSCD_CMD_HBIN 8'ha3
`define CSCD_CMD_VBIN 8'ha4
`define CSCD_CMD_MIRR 8'hc1
// ****************************************
// lengths, encodings, reset values
// ****************************************
`define CSCD_LEN_OFS 8'h02
`define CSCD_LEN_FLAG 8'h01
`define CSCD_FLAG_OFF 8'h00
`define CSCD_FLAG_ON 8'h01
`define CSCD_OFS_RST 8'h00
`define CSCD_HI_ZERO 8'h00
`endif

// ### logic/cscd_pkg.sv
// types for the camera settings command decoder
package cscd_pkg;
	// one received or sent frame byte with its position marks
	typedef struct packed {
		logic [7:0] data;
		logic first;
		logic last;
	} cscd_byte_t;
	typedef enum logic [2:0] {
		CSCD_IDLE,
		CSCD_FLAG,
		CSCD_LEN,
		CSCD_DATA,
		CSCD_EXEC,
		CSCD_REPLY
	} cscd_state_t;
endpackage

// ### logic/cscd_decoder.sv
// camera settings command decoder: offset, binning and mirror settings
// Behaviour
// - command 0x83 reads/writes right-half offset
// - read reply: same code, flag 0, two bytes
// - offset bytes travel low byte first
// - 0xA3 horizontal binning, one byte, no write reply
// - horizontal binning 0x00 off, 0x01 on
// - 0xA4 vertical binning, one byte, read/write
// - vertical binning 0x00 off, 0x01 on
// - 0xC1 mirror output, one byte, read/write
// - mirror 0x00 off, 0x01 on
// - right offset independent of left offset
`timescale 1ns/100ps
`include "cscd_regs.svh"
module cscd_decoder
	import cscd_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	input wire cscd_byte_t I_RX,
	input wire logic I_RX_VALID,
	input wire logic I_TX_READY,
	output cscd_byte_t O_TX,
	output logic O_TX_VALID,
	output logic [7:0] O_RIGHT_OFFSET,
	output logic O_HBIN_EN,
	output logic O_VBIN_EN,
	output logic O_MIRROR_EN
);
	// ****************************************
	// frame parsing
	// ****************************************
	cscd_state_t state;
	logic [7:0] cmd;
	logic rd;
	logic [7:0] len;
	logic [7:0] d0;
	logic [7:0] d1;
	logic [7:0] cnt;
	logic [1:0] tx_idx;
	logic [7:0] tx_byte;

	// command decode and validity of the stored frame
	wire is_ofs = (cmd == `CSCD_CMD_ROFS);
	wire is_h = (cmd == `CSCD_CMD_HBIN);
	wire is_v = (cmd == `CSCD_CMD_VBIN);
	wire is_m = (cmd == `CSCD_CMD_MIRR);
	// unknown codes fall through to a silent ignore
	wire known = is_ofs | is_h | is_v | is_m;
	// a flag command carries one byte, the offset two
	wire [7:0] need_len = is_ofs ? `CSCD_LEN_OFS : `CSCD_LEN_FLAG;
	wire len_ok = (len == need_len);
	// a flag byte must be exactly 0 or 1; offset high byte must be zero
	wire flag_ok = (d0 == `CSCD_FLAG_OFF) || (d0 == `CSCD_FLAG_ON);
	wire ofs_ok = (d1 == `CSCD_HI_ZERO);
	wire wr_ok = known && !rd && len_ok && (is_ofs ? ofs_ok : flag_ok);
	wire rd_ok = known && rd && len_ok;
	wire [7:0] cur_flag = is_h ? {7'h00, O_HBIN_EN} :
		is_v ? {7'h00, O_VBIN_EN} : {7'h00, O_MIRROR_EN};
	// reply: code, flag 0, length, data low byte first
	always_comb begin
		case (tx_idx)
			2'h0: tx_byte = cmd;
			2'h1: tx_byte = 8'h00;
			2'h2: tx_byte = need_len;
			default: tx_byte = is_ofs ? O_RIGHT_OFFSET : cur_flag;
		endcase
	end
	// reply byte count: code, flag, length and the data bytes
	wire [2:0] rep_len = is_ofs ? 3'h5 : 3'h4;

	// frame state machine; a first-marked byte restarts parsing in every state but CSCD_REPLY
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			state <= CSCD_IDLE;
			cmd <= 8'h00;
			rd <= 1'b0;
			len <= 8'h00;
			d0 <= 8'h00;
			d1 <= 8'h00;
			cnt <= 8'h00;
			tx_idx <= 2'h0;
		end else if (state != CSCD_REPLY && I_RX_VALID && I_RX.first) begin
			cmd <= I_RX.data;
			d0 <= 8'h00;
			d1 <= 8'h00;
			state <= CSCD_FLAG;
		end else begin
			case (state)
				CSCD_FLAG: begin
					if (I_RX_VALID) begin
						rd <= I_RX.data[0];
						state <= CSCD_LEN;
					end
				end
				CSCD_LEN: begin
					if (I_RX_VALID) begin
						len <= I_RX.data;
						cnt <= 8'h00;
						// reads carry no data bytes
						state <= (rd || I_RX.data == 8'h00) ? CSCD_EXEC : CSCD_DATA;
					end
				end
				CSCD_DATA: begin
					if (I_RX_VALID) begin
						if (cnt == 8'h00) d0 <= I_RX.data;
						if (cnt == 8'h01) d1 <= I_RX.data;
						cnt <= cnt + 8'h01;
						if (cnt + 8'h01 == len) state <= CSCD_EXEC;
					end
				end
				CSCD_EXEC: begin
					tx_idx <= 2'h0;
					cnt <= 8'h00;
					state <= rd_ok ? CSCD_REPLY : CSCD_IDLE; // no reply to writes
				end
				CSCD_REPLY: begin
					if (I_TX_READY && O_TX_VALID) begin
						if (cnt == {5'h00, rep_len} - 8'h01) begin
							state <= CSCD_IDLE;
						end else begin
							cnt <= cnt + 8'h01;
							if (tx_idx != 2'h3) tx_idx <= tx_idx + 2'h1;
						end
					end
				end
				default: state <= CSCD_IDLE;
			endcase
		end
	end

	// ****************************************
	// settings, updated only by a well formed write
	// ****************************************
	// left offset (0x81) is not decoded here, so it can never disturb this one
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_RIGHT_OFFSET <= `CSCD_OFS_RST;
			O_HBIN_EN <= 1'b0;
			O_VBIN_EN <= 1'b0;
			O_MIRROR_EN <= 1'b0;
		end else if (state == CSCD_EXEC && wr_ok) begin
			if (is_ofs) O_RIGHT_OFFSET <= d0;
			if (is_h) O_HBIN_EN <= d0[0];
			if (is_v) O_VBIN_EN <= d0[0]; // independent of horizontal
			if (is_m) O_MIRROR_EN <= d0[0];
		end
	end

	// byte that follows the one now presented; picking it by cnt instead of
	// shifting a preloaded reply keeps the sender to one byte register
	wire [7:0] nxt_data = (cnt == 8'h00) ? 8'h00 :
		(cnt == 8'h01) ? need_len :
		(cnt == 8'h02) ? (is_ofs ? O_RIGHT_OFFSET : cur_flag) : `CSCD_HI_ZERO;

	// reply byte register; held while the sink stalls
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_TX <= '0;
			O_TX_VALID <= 1'b0;
		end else if (!O_TX_VALID || I_TX_READY) begin
			O_TX_VALID <= (state == CSCD_REPLY) &&
				!(O_TX_VALID && cnt == {5'h00, rep_len} - 8'h01);
			O_TX.data <= (O_TX_VALID && state == CSCD_REPLY) ? nxt_data : tx_byte;
			O_TX.first <= !(O_TX_VALID && state == CSCD_REPLY);
			O_TX.last <= O_TX_VALID && (cnt + 8'h02 == {5'h00, rep_len});
		end
	end

	// ****************************************
	// checks
	// ****************************************
	// a frame at its execute step; sel names the setting it addresses
	sequence wr_exec_s(sel);
		state == CSCD_EXEC && wr_ok && sel;
	endsequence
	sequence rd_exec_s;
		state == CSCD_EXEC && rd_ok;
	endsequence
	// the code byte of a reply as the sink takes it
	sequence code_taken_s;
		O_TX_VALID && I_TX_READY && O_TX.first;
	endsequence

	// reply framing: code first, flag byte next, nothing after the last byte
	reply_code_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		O_TX_VALID && O_TX.first |-> O_TX.data == cmd) else $error("reply code wrong");
	flag_byte_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		code_taken_s |=> O_TX_VALID && !O_TX.first && O_TX.data == 8'h00)
		else $error("reply flag byte wrong");
	reply_end_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		O_TX_VALID && I_TX_READY && O_TX.last |=> !O_TX_VALID) else $error("reply overran");
	// a stalled byte must not move, or the host would lose or repeat it
	reply_hold_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX)) else $error("byte moved");
	read_reply_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		rd_exec_s |-> ##[1:3] O_TX_VALID) else $error("no read reply");
	// reply data: offset high byte zero, flag byte the addressed setting
	ofs_high_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		O_TX_VALID && O_TX.last && is_ofs |-> O_TX.data == `CSCD_HI_ZERO)
		else $error("offset high byte not zero");
	flag_reply_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		O_TX_VALID && O_TX.last && !is_ofs |-> O_TX.data == {7'h00,
		(is_h & O_HBIN_EN) | (is_v & O_VBIN_EN) | (is_m & O_MIRROR_EN)})
		else $error("flag reply wrong");
	// writes: no reply, the addressed setting takes the value, an hbin write leaves the others alone
	no_wr_reply_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		state == CSCD_EXEC && !rd |=> state != CSCD_REPLY) else $error("write replied");
	ofs_write_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		wr_exec_s(is_ofs) |=> O_RIGHT_OFFSET == $past(d0)) else $error("offset not stored");
	lofs_keep_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		state == CSCD_EXEC && cmd == `CSCD_CMD_LOFS |=> $stable(O_RIGHT_OFFSET))
		else $error("left offset write hit right offset");
	hbin_set_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		wr_exec_s(is_h) |=> O_HBIN_EN == $past(d0[0])) else $error("hbin not stored");
	hbin_keep_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		wr_exec_s(is_h) |=> $stable({O_VBIN_EN, O_MIRROR_EN, O_RIGHT_OFFSET}))
		else $error("hbin write disturbed others");
	vbin_set_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		wr_exec_s(is_v) |=> O_VBIN_EN == $past(d0[0]) && $stable(O_HBIN_EN))
		else $error("vbin not stored");
	mirror_set_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		wr_exec_s(is_m) |=> O_MIRROR_EN == $past(d0[0])) else $error("mirror not stored");
	// a refused write, or any read, leaves every setting alone
	bad_write_a: assert property (@(posedge I_MCLK) disable iff (I_SYS_RST)
		state == CSCD_EXEC && !wr_ok |=> $stable({O_RIGHT_OFFSET, O_HBIN_EN, O_VBIN_EN,
		O_MIRROR_EN})) else $error("bad write changed setting");
endmodule

// ### tb/cscd_host_model.sv
// host side reply sink, ready steady or stalling
`timescale 1ns/100ps
module cscd_host_model
	import cscd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_slow,
	input wire cscd_byte_t i_tx,
	input wire logic i_tx_valid,
	output logic o_ready = 1'b1
);
	cscd_byte_t got [$];
	logic [1:0] tick = 2'h0;
	// stall three cycles in four when slow, so each reply byte must hold
	always @(posedge i_clk) begin
		tick <= tick + 2'h1;
		o_ready <= !i_slow || tick == 2'h0;
		if (i_tx_valid && o_ready) got.push_back(i_tx);
	end
endmodule

// ### tb/testbench.sv
// self-checking bench for the settings command decoder
`timescale 1ns/100ps
`include "cscd_regs.svh"
module testbench;
	import cscd_pkg::*;
	logic I_MCLK = 1'b0, I_SYS_RST = 1'b1, I_RX_VALID = 1'b0, slow = 1'b0, rdy;
	logic O_TX_VALID, O_HBIN_EN, O_VBIN_EN, O_MIRROR_EN;
	cscd_byte_t I_RX = '0;
	cscd_byte_t O_TX;
	logic [7:0] O_RIGHT_OFFSET, e;
	logic [7:0] codes [3] = '{`CSCD_CMD_HBIN, `CSCD_CMD_VBIN, `CSCD_CMD_MIRR};
	wire [2:0] flags = {O_HBIN_EN, O_VBIN_EN, O_MIRROR_EN};
	int n_mismatch = 0, n_checks = 0;
	always #25 I_MCLK = ~I_MCLK;
	cscd_decoder dut(.I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_RX(I_RX),
		.I_RX_VALID(I_RX_VALID), .I_TX_READY(rdy), .O_TX(O_TX),
		.O_TX_VALID(O_TX_VALID), .O_RIGHT_OFFSET(O_RIGHT_OFFSET),
		.O_HBIN_EN(O_HBIN_EN), .O_VBIN_EN(O_VBIN_EN), .O_MIRROR_EN(O_MIRROR_EN));
	cscd_host_model host(.i_clk(I_MCLK), .i_slow(slow), .i_tx(O_TX),
		.i_tx_valid(O_TX_VALID), .o_ready(rdy));
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(logic [7:0] d, logic f, logic l);
		@(posedge I_MCLK);
		I_RX <= '{data: d, first: f, last: l};
		I_RX_VALID <= 1'b1;
	endtask
	// bytes go back to back; data follows only on writes
	task automatic frame(logic [7:0] c, rw, n, d0, d1);
		put(c, 1'b1, 1'b0);
		put(rw, 1'b0, 1'b0);
		put(n, 1'b0, rw[0]);
		if (!rw[0]) put(d0, 1'b0, n == 8'h01);
		if (!rw[0] && n > 8'h01) put(d1, 1'b0, 1'b1);
		@(posedge I_MCLK);
		I_RX_VALID <= 1'b0;
		repeat (4) @(posedge I_MCLK);
	endtask
	task automatic rd(logic [7:0] c, n, d0, d1);
		cscd_byte_t q [$];
		host.got = {};
		frame(c, 8'h01, n, 8'h00, 8'h00);
		for (int k = 0; k < 60 && host.got.size() < 3 + n; k++) @(posedge I_MCLK);
		q = host.got;
		check("reply count", 8'(q.size()), n + 8'h03);
		check("reply code", q[0].data, c);
		check("reply flag", q[1].data, 8'h00);
		check("reply length", q[2].data, n);
		check("reply low", q[3].data, d0);
		if (n > 8'h01) check("reply high", q[4].data, d1);
		check("reply marks", {6'h00, q[0].first, q[2 + n].last}, 8'h03);
	endtask
	// outputs come out of reset cleared and stay so past the first edge
	task automatic t_reset();
		@(posedge I_MCLK);
		check("reset offset", O_RIGHT_OFFSET, `CSCD_OFS_RST);
		check("reset flags", {4'h0, flags, O_TX_VALID}, 8'h00);
	endtask
	// a reset in mid-run clears settings that writes had set
	task automatic t_midreset();
		frame(`CSCD_CMD_MIRR, 8'h00, 8'h01, `CSCD_FLAG_ON, 8'h00);
		check("mirror before reset", {5'h00, flags}, 8'h01);
		I_SYS_RST <= 1'b1;
		repeat (2) @(posedge I_MCLK);
		I_SYS_RST <= 1'b0;
		t_reset();
	endtask
	task automatic t_offset();
		slow <= 1'b1;
		frame(`CSCD_CMD_ROFS, 8'h00, 8'h02, 8'h5a, 8'h00);
		check("offset write", O_RIGHT_OFFSET, 8'h5a);
		rd(`CSCD_CMD_ROFS, 8'h02, 8'h5a, 8'h00);
		frame(`CSCD_CMD_ROFS, 8'h00, 8'h02, 8'h33, 8'h01);
		check("offset high set", O_RIGHT_OFFSET, 8'h5a);
		frame(`CSCD_CMD_LOFS, 8'h00, 8'h02, 8'h11, 8'h00);
		check("left offset", O_RIGHT_OFFSET, 8'h5a);
		frame(`CSCD_CMD_ROFS, 8'h00, 8'h02, 8'hff, 8'h00);
		check("offset top", O_RIGHT_OFFSET, 8'hff);
		slow <= 1'b0;
	endtask
	// settings build up one by one, so a cross-coupled enable shows
	task automatic t_flags();
		for (int i = 0; i < 3; i++) begin
			host.got = {};
			e = (8'h07 << (2 - i)) & 8'h07;
			frame(codes[i], 8'h00, 8'h01, `CSCD_FLAG_ON, 8'h00);
			check("flag on", {5'h00, flags}, e);
			check("write reply", 8'(host.got.size()), 8'h00);
			rd(codes[i], 8'h01, 8'h01, 8'h00);
			frame(codes[i], 8'h00, 8'h01, 8'h02, 8'h00);
			check("bad value", {5'h00, flags}, e);
			frame(codes[i], 8'h00, 8'h02, 8'h00, 8'h00);
			check("bad length", {5'h00, flags}, e);
		end
		for (int i = 0; i < 3; i++) begin
			frame(codes[i], 8'h00, 8'h01, `CSCD_FLAG_OFF, 8'h00);
			check("flag off", {5'h00, flags}, 8'h07 >> (i + 1));
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge I_MCLK);
		I_SYS_RST <= 1'b0;
		t_reset();
		t_offset();
		t_flags();
		t_midreset();
		close_out();
	end
	// backstop only: the reply wait in rd gives up after 60 cycles, so no wait can stall the run
	initial begin
		#500000;
		n_mismatch++;
		close_out();
	end
endmodule
